// File: logic/srs_pkg.sv
// constants, state codes and field positions for the streaming read port
// assumes every user writes srs_pkg::name and never imports
package srs_pkg;
    // checksum generator
    localparam logic [15:0] SRS_CRC_POLY = 16'h8005;
    localparam logic [15:0] SRS_CRC_RST = 16'h0000;
    localparam logic [5:0] SRS_CRC_LEN16 = 6'h10;
    localparam logic [5:0] SRS_CRC_LEN32 = 6'h20;
    // unit lengths and register addresses
    localparam logic [5:0] SRS_STAT_LEN = 6'h08;
    localparam logic [3:0] SRS_ADDR_RESULT = 4'h0;
    localparam logic [3:0] SRS_ADDR_LAST = 4'hf;
    // status byte field positions
    localparam int SRS_STAT_DR_BIT = 2;
    localparam int SRS_STAT_TOP_BIT = 7;
    // values after reset
    localparam logic SRS_DR_FLAG_RST = 1'b1;
    localparam logic SRS_CS_IDLE_RST = 1'b1;
    localparam logic SRS_SCK_IDLE_RST = 1'b0;

    // serial unit being shifted out
    typedef enum logic [3:0]
    {
        SRS_IDLE = 4'b0001,
        SRS_STAT = 4'b0010,
        SRS_DATA = 4'b0100,
        SRS_CRC = 4'b1000
    } srs_phase_t;
endpackage

// File: logic/srs_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes pins are asynchronous to clk; first stage read only by second
module srs_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // pin side
    input wire logic [W-1:0] d,
    // synchronised side
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // two-stage capture
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end
        else if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: logic/srs_crc16.sv
// serial 16-bit checksum generator, msb first
// assumes step and clr come from the same clock domain
module srs_crc16 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // control
    input wire logic clr,
    input wire logic step,
    input wire logic din,
    // checksum
    output logic [15:0] crc
);
    logic fb;
    logic [15:0] shifted;
    logic [15:0] crc_nxt;

    // one bit of polynomial division
    assign fb = crc[15] ^ din;
    assign shifted = {crc[14:0], 1'b0};
    assign crc_nxt = fb ? (shifted ^ srs_pkg::SRS_CRC_POLY) : shifted;

    // checksum register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            crc <= srs_pkg::SRS_CRC_RST;
        else if (ce && clr)
            crc <= srs_pkg::SRS_CRC_RST;
        else if (ce && step)
            crc <= crc_nxt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    poly_check_a: assert property (ce && step && !clr && crc == 16'h0000 && din
        |=> crc == 16'h8005)
        else $error("checksum polynomial step wrong");
endmodule

// File: logic/srs_read_stream.sv
// read-side serial output path: status, register stream, checksum
// assumes sck and cs_b are raw pins; command fields come from a decoder on mclk
// Function
// - static read of result register streams results
// - result double buffered against mid-read updates
// - stream continues until chip select rises
// - mode 0,0: msb shown after last falling edge
// - mode 0,0 idle: new msb at ready event
// - mode 1,1: lsb held until clocking resumes
// - checksum appending switched by enable bit
// - checksum polynomial 0x8005, sixteen bits
// - static read: checksum after every register
// - incremental read: checksum after address 0xF
// - first checksum covers status byte too
// - format bit: 16-bit or appended zero word
// - same checksum value for both formats
// - static read repeats the same register
// - incremental read wraps 0xF to 0x0
// - register captured at first rising edge
// - ready flag low until status sent
module srs_read_stream #(
    parameter int RES_W = 24
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // serial pins
    input wire logic sck_i,
    input wire logic cs_b_i,
    output logic sdo_o,
    output logic sdo_oe,
    // command decoder, valid by end of status byte; status_in sampled at chip select fall
    input wire logic cmd_read,
    input wire logic cmd_static,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] status_in,
    // register file read port, data left-justified
    output logic [3:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic [5:0] reg_len,
    // conversion results
    input wire logic [RES_W-1:0] result_in,
    input wire logic result_ready,
    // third_config_register fields
    input wire logic comm_checksum_enable,
    input wire logic crc_format_32,
    // status
    output logic data_ready_flag_b,
    output logic [15:0] comm_checksum_value
);
    ////////////////////////////////////////////////////////////////////////
    // parameter check
    generate
        if (RES_W < 8 || RES_W > 32)
        begin : g_bad_width
            $error("result width must be 8 to 32");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection
    logic [1:0] pin_s;
    logic sck_s, cs_b_s, sck_q_r, cs_q_r;
    logic sck_rise, sck_fall, cs_fall, cs_rise, rdy;

    srs_sync #(.W(2), .RST_VAL({srs_pkg::SRS_SCK_IDLE_RST, srs_pkg::SRS_CS_IDLE_RST})) u_sync (
        .clk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .d({sck_i, cs_b_i}),
        .q(pin_s)
    );

    // split and find edges
    assign sck_s = pin_s[1];
    assign cs_b_s = pin_s[0];
    assign sck_rise = ce & sck_s & ~sck_q_r;
    assign sck_fall = ce & ~sck_s & sck_q_r;
    assign cs_fall = ce & ~cs_b_s & cs_q_r;
    assign cs_rise = ce & cs_b_s & ~cs_q_r;
    assign rdy = ce & result_ready;

    // previous pin levels
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            sck_q_r <= srs_pkg::SRS_SCK_IDLE_RST;
            cs_q_r <= srs_pkg::SRS_CS_IDLE_RST;
        end
        else if (ce)
        begin
            sck_q_r <= sck_s;
            cs_q_r <= cs_b_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    srs_pkg::srs_phase_t phase_r, phase_nxt;
    logic [5:0] bit_idx_r;
    logic [3:0] addr_r, start_addr_r, next_addr;
    logic static_r, cpol_r, dr_flag_b_r, pend_r, sdo_r, oe_r;
    logic [7:0] status_r;
    logic [31:0] sh_r;
    logic [RES_W-1:0] hold_r, pend_val_r;
    logic [15:0] crc_val;

    ////////////////////////////////////////////////////////////////////////
    // unit decoding
    logic is_result, active, unit_end, crc_due, lock, in_data, res_end;
    logic stat_end, crc_end, crc_step, crc_clr, idle_refresh;
    logic [31:0] result_word, cur_word;
    logic [5:0] cur_len;

    // length of the current unit in bits
    function automatic logic [5:0] unit_len_f(srs_pkg::srs_phase_t ph, logic res,
                                                logic fmt32, logic [5:0] rlen);
        logic [5:0] len;
        len = rlen;
        if (ph == srs_pkg::SRS_STAT)
            len = srs_pkg::SRS_STAT_LEN;
        else if (ph == srs_pkg::SRS_CRC)
            len = fmt32 ? srs_pkg::SRS_CRC_LEN32 : srs_pkg::SRS_CRC_LEN16;
        else if (res)
            len = 6'(RES_W);
        return len;
    endfunction

    // word and length selection
    assign is_result = addr_r == srs_pkg::SRS_ADDR_RESULT;
    assign active = phase_r != srs_pkg::SRS_IDLE;
    assign in_data = phase_r == srs_pkg::SRS_DATA;
    assign result_word = 32'(hold_r) << (32 - RES_W);
    // checksum word: value then zero low half, same value either format
    assign cur_word = (phase_r == srs_pkg::SRS_STAT) ? {status_r, 24'h000000} :
                      (phase_r == srs_pkg::SRS_CRC) ? {crc_val, 16'h0000} :
                      is_result ? result_word : reg_rdata;
    assign cur_len = unit_len_f(phase_r, is_result, crc_format_32, reg_len);
    assign unit_end = bit_idx_r == (cur_len - 6'h01);
    // checksum after every static read, after 0xF when incremental
    assign crc_due = comm_checksum_enable
        & (static_r | addr_r == srs_pkg::SRS_ADDR_LAST);
    assign next_addr = static_r ? addr_r : addr_r + 4'h1;
    assign lock = in_data & is_result & (bit_idx_r != 6'h00);
    assign res_end = sck_rise & in_data & is_result & unit_end;
    assign stat_end = sck_rise & (phase_r == srs_pkg::SRS_STAT) & unit_end;
    assign crc_end = sck_rise & (phase_r == srs_pkg::SRS_CRC) & unit_end;
    // mode 0,0 idle between results: ready event refreshes msb
    assign idle_refresh = rdy & in_data & is_result & (bit_idx_r == 6'h00) & ~cpol_r;

    // next unit after the current one ends
    always_comb
    begin
        unique case (phase_r)
            srs_pkg::SRS_STAT: phase_nxt = cmd_read ? srs_pkg::SRS_DATA : srs_pkg::SRS_IDLE;
            srs_pkg::SRS_DATA: phase_nxt = crc_due ? srs_pkg::SRS_CRC : phase_r;
            srs_pkg::SRS_CRC: phase_nxt = srs_pkg::SRS_DATA;
            default: phase_nxt = srs_pkg::SRS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing: phase, bit count, address
    always_ff @(posedge mclk)
    begin
        if (!rst_b || cs_rise)
        begin
            phase_r <= srs_pkg::SRS_IDLE;
            bit_idx_r <= 6'h00;
        end
        else if (cs_fall)
        begin
            phase_r <= srs_pkg::SRS_STAT;
            bit_idx_r <= 6'h00;
        end
        else if (sck_rise && active)
        begin
            bit_idx_r <= unit_end ? 6'h00 : bit_idx_r + 6'h01;
            phase_r <= unit_end ? phase_nxt : phase_r;
        end
    end

    // command latch and address pointer
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            addr_r <= srs_pkg::SRS_ADDR_RESULT;
            start_addr_r <= srs_pkg::SRS_ADDR_RESULT;
            static_r <= 1'b0;
        end
        else if (stat_end)
        begin
            addr_r <= cmd_addr;
            start_addr_r <= cmd_addr;
            static_r <= cmd_static;
        end
        else if (sck_rise && in_data && unit_end)
            addr_r <= next_addr;
    end

    // frame start: clock polarity and status byte
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cpol_r <= srs_pkg::SRS_SCK_IDLE_RST;
            status_r <= 8'h00;
        end
        else if (cs_fall)
        begin
            cpol_r <= sck_s;
            status_r <= status_in;
            status_r[srs_pkg::SRS_STAT_DR_BIT] <= dr_flag_b_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register: capture at first rising edge, shift after each
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            sh_r <= 32'h00000000;
        else if (sck_rise && active)
            sh_r <= ((bit_idx_r == 6'h00) ? cur_word : sh_r) << 1;
    end

    // serial output: changes on falling edges or idle refresh
    always_ff @(posedge mclk)
    begin
        if (!rst_b || cs_rise)
        begin
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else if (cs_fall)
        begin
            sdo_r <= status_in[srs_pkg::SRS_STAT_TOP_BIT];
            oe_r <= 1'b1;
        end
        else if (stat_end && !cmd_read)
            oe_r <= 1'b0;
        else if (sck_fall && active)
            sdo_r <= (bit_idx_r == 6'h00) ? cur_word[31] : sh_r[31];
        else if (idle_refresh)
            sdo_r <= result_in[RES_W-1];
    end

    ////////////////////////////////////////////////////////////////////////
    // result double buffer
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            hold_r <= '0;
            pend_val_r <= '0;
            pend_r <= 1'b0;
        end
        else if (rdy && !(lock && !res_end))
        begin
            hold_r <= result_in;
            pend_r <= 1'b0;
        end
        else if (rdy)
        begin
            pend_val_r <= result_in;
            pend_r <= 1'b1;
        end
        else if (ce && pend_r && !lock)
        begin
            hold_r <= pend_val_r;
            pend_r <= 1'b0;
        end
    end

    // data ready flag: set by event wins over clear by status byte
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            dr_flag_b_r <= srs_pkg::SRS_DR_FLAG_RST;
        else if (rdy)
            dr_flag_b_r <= 1'b0;
        else if (stat_end)
            dr_flag_b_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // checksum over status and data bits as they leave the pin
    assign crc_step = sck_rise & (phase_r == srs_pkg::SRS_STAT | in_data);
    assign crc_clr = cs_fall | crc_end;

    srs_crc16 u_crc (
        .clk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .clr(crc_clr),
        .step(crc_step),
        .din(sdo_r),
        .crc(crc_val)
    );

    // outputs
    assign sdo_o = sdo_r;
    assign sdo_oe = oe_r;
    assign reg_addr = addr_r;
    assign data_ready_flag_b = dr_flag_b_r;
    assign comm_checksum_value = crc_val;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_data_end;
        sck_rise && active && in_data && unit_end;
    endsequence

    sequence s_result_idle_fall;
        sck_fall && in_data && is_result && bit_idx_r == 6'h00 && !rdy;
    endsequence

    hold_frozen_a: assert property (lock && !res_end |=> $stable(hold_r))
        else $error("result changed during its read");
    static_addr_a: assert property (in_data && static_r |-> addr_r == start_addr_r)
        else $error("static read moved address");
    addr_wrap_a: assert property (s_data_end ##0 (!static_r && addr_r == 4'hf)
        |=> addr_r == 4'h0)
        else $error("incremental read did not wrap");
    crc_static_a: assert property (s_data_end ##0 (comm_checksum_enable && static_r)
        |=> phase_r == srs_pkg::SRS_CRC)
        else $error("no checksum after static read");
    crc_off_a: assert property (s_data_end ##0 !comm_checksum_enable
        |=> phase_r == srs_pkg::SRS_DATA)
        else $error("checksum sent while disabled");
    crc_incr_a: assert property (s_data_end ##0 (!static_r && addr_r != 4'hf)
        |=> phase_r == srs_pkg::SRS_DATA)
        else $error("checksum before last register");
    crc_clear_a: assert property (cs_fall |=> crc_val == 16'h0000)
        else $error("checksum not cleared at frame start");
    crc_len_a: assert property (phase_r == srs_pkg::SRS_CRC
        |-> cur_len == (crc_format_32 ? 6'h20 : 6'h10))
        else $error("checksum length wrong");
    msb_preview_a: assert property (s_result_idle_fall |=> sdo_o == hold_r[RES_W-1])
        else $error("idle output not result msb");
    dr_flag_a: assert property (rdy |=> !data_ready_flag_b)
        else $error("ready flag not set by event");
endmodule

// File: testbench/srs_host.sv
// behavioural spi host for the streaming read port, clocks sck and frames cs_b
// assumes clk is the device mclk; sck half period is four clk cycles (800 ns period)
module srs_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic sck,
    output logic cs_b,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [63:0] rx;
    logic mode11;

    ////////////////////////////////////////////////////////////////////////////////
    // pins idle: cs high, sck stands still outside frames
    initial
    begin
        sck = 1'b0;
        cs_b = 1'b1;
        rx = 64'h0;
        mode11 = 1'b0;
    end

    // open a frame; sck idle level picks mode 0,0 or 1,1
    task automatic start(input logic m11);
        sck <= m11;
        mode11 = m11;
        repeat (4) @(posedge clk);
        cs_b <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // clock n bits, sampling sdo on each rising edge, msb first into rx
    task automatic bits(input int n);
        for (int i = 0; i < n; i++)
        begin
            sck <= 1'b0;
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            rx <= {rx[62:0], sdo};
            repeat (4) @(posedge clk);
        end
        // mode 0,0 ends each burst with the final falling edge
        if (!mode11)
        begin
            sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // end the frame and park sck at its idle level
    task automatic stop;
        cs_b <= 1'b1;
        sck <= mode11;
        repeat (8) @(posedge clk);
    endtask
endmodule

// File: testbench/srs_read_stream_tb.sv
// self-checking bench for the streaming read port
// assumes srs_host as far side; register file modelled by a continuous assignment
module srs_read_stream_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk, rst_b, ce, sck, cs_b, sdo_o, sdo_oe, sdo_pin, cmd_read, cmd_static;
    logic [3:0] cmd_addr, reg_addr;
    logic [7:0] status_in;
    logic [31:0] reg_rdata;
    logic [5:0] reg_len;
    logic [23:0] result_in;
    logic result_ready, comm_checksum_enable, crc_format_32, data_ready_flag_b;
    logic [15:0] comm_checksum_value;
    int mismatches, n_compared;

    ////////////////////////////////////////////////////////////////////////////////
    // device, far side and register file
    srs_read_stream #(.RES_W(24)) dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .sck_i(sck),
        .cs_b_i(cs_b), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cmd_read(cmd_read),
        .cmd_static(cmd_static), .cmd_addr(cmd_addr), .status_in(status_in),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_len(reg_len),
        .result_in(result_in), .result_ready(result_ready),
        .comm_checksum_enable(comm_checksum_enable), .crc_format_32(crc_format_32),
        .data_ready_flag_b(data_ready_flag_b), .comm_checksum_value(comm_checksum_value));
    // released line shows the inverse of the last bit, never a stale value
    assign sdo_pin = sdo_oe ? sdo_o : ~sdo_o;
    srs_host host (.clk(mclk), .sck(sck), .cs_b(cs_b), .sdo(sdo_pin));
    // registers read as address nibble patterns; 0xf is sixteen bits, others eight
    assign reg_rdata = {reg_addr, ~reg_addr, ~reg_addr, reg_addr, reg_addr, ~reg_addr,
        ~reg_addr, reg_addr};
    assign reg_len = (reg_addr == 4'hf) ? 6'h10 : 6'h08;

    // clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] crc_of(input logic [63:0] v, input int n);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? srs_pkg::SRS_CRC_POLY : 16'h0000);
        return c;
    endfunction
    function automatic logic [7:0] stat_exp(input logic [7:0] s0, input logic fl);
        logic [7:0] s;
        s = s0;
        s[srs_pkg::SRS_STAT_DR_BIT] = fl;
        return s;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [23:0] v);
        result_in <= v;
        result_ready <= 1'b1;
        @(posedge mclk);
        result_ready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // static result stream with 16-bit checksum, new result mid-read
    task automatic t_stream;
        pulse(24'hc35a17);
        repeat (10) @(posedge mclk);
        host.start(1'b0);
        host.bits(8);
        chk(64'(host.rx[7:0]), 64'(stat_exp(8'h37, 1'b0)));
        host.bits(24);
        chk(64'(host.rx[23:0]), 64'hc35a17);
        chk(64'(comm_checksum_value),
            64'(crc_of(64'({stat_exp(8'h37, 1'b0), 24'hc35a17}), 32)));
        host.bits(16);
        chk(64'(host.rx[15:0]),
            64'(crc_of(64'({stat_exp(8'h37, 1'b0), 24'hc35a17}), 32)));
        chk(64'(crc_of(64'(host.rx[47:0]), 48)), 64'h0);
        host.bits(4);
        pulse(24'h3e81d4);
        host.bits(20);
        chk(64'(host.rx[23:0]), 64'hc35a17);
        host.bits(16);
        chk(64'(host.rx[15:0]), 64'(crc_of(64'h00c35a17, 24)));
        host.bits(24);
        chk(64'(host.rx[23:0]), 64'h3e81d4);
        host.stop;
        chk(64'(sdo_oe), 64'h0);
    endtask

    // mode 0,0 idle behaviour at a result boundary, checksum off
    task automatic t_idle00;
        comm_checksum_enable <= 1'b0;
        pulse(24'hda0f96);
        repeat (10) @(posedge mclk);
        host.start(1'b0);
        host.bits(32);
        chk(64'(host.rx[23:0]), 64'hda0f96);
        repeat (4) @(posedge mclk);
        chk(64'(sdo_o), 64'h1);
        pulse(24'h1c33e1);
        repeat (6) @(posedge mclk);
        chk(64'(sdo_o), 64'h0);
        // clock enable low: a ready event must be ignored entirely
        ce <= 1'b0;
        pulse(24'h9b27c5);
        ce <= 1'b1;
        chk(64'(sdo_o), 64'h0);
        host.bits(24);
        chk(64'(host.rx[23:0]), 64'h1c33e1);
        host.stop;
    endtask

    // mode 1,1 holds the lsb, no refresh on a new result
    task automatic t_idle11;
        pulse(24'h2d4e71);
        repeat (10) @(posedge mclk);
        host.start(1'b1);
        host.bits(32);
        chk(64'(host.rx[23:0]), 64'h2d4e71);
        repeat (8) @(posedge mclk);
        chk(64'(sdo_o), 64'h1);
        pulse(24'h4e1f30);
        repeat (8) @(posedge mclk);
        chk(64'(sdo_o), 64'h1);
        host.stop;
    endtask

    // incremental read from 0xe, 32-bit checksum format, wrap to result register
    task automatic t_incr;
        comm_checksum_enable <= 1'b1;
        crc_format_32 <= 1'b1;
        cmd_static <= 1'b0;
        cmd_addr <= 4'he;
        host.start(1'b0);
        host.bits(16);
        chk(64'(host.rx[7:0]), 64'he1);
        host.bits(16);
        chk(64'(host.rx[15:0]), 64'hf00f);
        host.bits(16);
        chk(64'(host.rx[15:0]),
            64'(crc_of(64'({stat_exp(8'h37, 1'b0), 24'he1f00f}), 32)));
        host.bits(16);
        chk(64'(host.rx[15:0]), 64'h0);
        host.bits(24);
        chk(64'(host.rx[23:0]), 64'h4e1f30);
        host.stop;
    endtask

    // non-read command: status byte only, then the output is released
    task automatic t_noread;
        cmd_read <= 1'b0;
        status_in <= 8'hc4;
        pulse(24'h5a96c3);
        chk(64'(data_ready_flag_b), 64'h0);
        host.start(1'b0);
        chk(64'(sdo_oe), 64'h1);
        host.bits(8);
        chk(64'(host.rx[7:0]), 64'(stat_exp(8'hc4, 1'b0)));
        chk(64'(data_ready_flag_b), 64'h1);
        chk(64'(sdo_oe), 64'h0);
        host.stop;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        mismatches = 0;
        n_compared = 0;
        rst_b <= 1'b0;
        ce <= 1'b1;
        cmd_read <= 1'b1;
        cmd_static <= 1'b1;
        cmd_addr <= 4'h0;
        status_in <= 8'h37;
        result_in <= 24'h000000;
        result_ready <= 1'b0;
        comm_checksum_enable <= 1'b1;
        crc_format_32 <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_stream;
        t_idle00;
        t_idle11;
        t_incr;
        t_noread;
        test_done;
    end
endmodule
